/* File: iakw_pkg.sv */
package iakw_pkg;

  // ****************************************************************
  // Source and flag layout
  // ****************************************************************
  localparam int          NUM_SRC      = 20;
  localparam int          FLAG_BITS    = 24;
  localparam int          KEY_IF_BIT   = 19;
  localparam logic [4:0]  NMI_VECTOR   = 5'h1F;

  // ****************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] IDX_IF0      = 16'hFFE0;
  localparam logic [15:0] IDX_IF1      = 16'hFFE1;
  localparam logic [15:0] IDX_IF2      = 16'hFFE2;
  localparam logic [15:0] IDX_MK0      = 16'hFFE4;
  localparam logic [15:0] IDX_MK1      = 16'hFFE5;
  localparam logic [15:0] IDX_MK2      = 16'hFFE6;
  localparam logic [15:0] IDX_KWS      = 16'hFFF5;
  localparam logic [15:0] IDX_PSW      = 16'hFFD0;
  localparam logic [15:0] IDX_PR0      = 16'hFFD1;
  localparam logic [15:0] IDX_PR1      = 16'hFFD2;
  localparam logic [15:0] IDX_PR2      = 16'hFFD3;
  localparam logic [15:0] IDX_SVC      = 16'hFFD4;

  // ****************************************************************
  // Status byte fields and reset values
  // ****************************************************************
  localparam int          PSW_IE       = 7;
  localparam int          PSW_Z        = 6;
  localparam int          PSW_AC       = 4;
  localparam int          PSW_ONE      = 1;
  localparam int          PSW_CY       = 0;
  localparam logic [7:0]  PSW_RESET    = 8'h02;
  localparam logic [7:0]  PSW_RW_MASK  = 8'hD1;
  localparam logic [7:0]  PSW_FIXED    = 8'h02;
  localparam logic [7:0]  KWS_RESET    = 8'h00;
  localparam logic [7:0]  KWS_RW_MASK  = 8'hF1;
  localparam int          KWS_GROUP    = 0;
  localparam logic [23:0] IF_RESET     = 24'h000000;
  localparam logic [23:0] MK_RESET     = 24'hFFFFFF;
  localparam logic [23:0] PR_RESET     = 24'hFFFFFF;
  localparam logic [23:0] SRC_MASK     = 24'h0FFFFF;

  // ****************************************************************
  // Bus encodings
  // ****************************************************************
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  HRESP_OKAY   = 2'h0;

endpackage

/* File: iakw_top.sv */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module iakw_top
  import iakw_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [1:0]  hresp,
  output var  logic [31:0] hrdata,
  // Interrupt sources
  input  wire logic [18:0] src_req,
  input  wire logic        nmi_req,
  input  wire logic [7:0]  p0_pin,
  // CPU core sequencer
  input  wire logic        instr_last,
  input  wire logic        instr_flag_access,
  input  wire logic        ei_strobe,
  input  wire logic        di_strobe,
  input  wire logic        alu_flags_we,
  input  wire logic        alu_z,
  input  wire logic        alu_ac,
  input  wire logic        alu_cy,
  input  wire logic        return_from_service_strobe,
  input  wire logic [7:0]  return_from_service_psw,
  // Service entry towards the core
  output var  logic        svc_start,
  output var  logic        svc_nmi,
  output var  logic [4:0]  svc_vector,
  output var  logic [7:0]  svc_saved_psw,
  output var  logic [7:0]  psw_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        bus_pend_q;
  logic        bus_wr_q;
  logic [15:0] bus_idx_q;
  logic        bus_ok_q;
  logic        addr_phase;
  logic [7:0]  psw_q;
  logic [7:0]  kws_q;
  logic [23:0] if_q;
  logic [23:0] if_d;
  logic [23:0] if_lanes;
  logic [23:0] mk_q;
  logic [23:0] pr_q;
  logic [23:0] pend_q;
  logic        nmi_q;
  logic [7:0]  p0_s1_q;
  logic [7:0]  p0_s2_q;
  logic        keys_high_q;
  logic [7:0]  key_sel;
  logic        keys_high;
  logic        key_event;
  logic [23:0] eligible;
  logic [23:0] ripe;
  logic [5:0]  pick;
  logic        take_nmi;
  logic        take_mask;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;
  logic        wr_en;
  logic [4:0]  last_vec_q;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Lowest index wins inside the high group (priority flag 0), then low
  function automatic logic [5:0] pick_src(input logic [23:0] req,
                                          input logic [23:0] prio);
    logic [5:0] res;
    res = 6'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && prio[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && !prio[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [23:0] lane_mask(input logic [15:0] idx,
                                            input logic [15:0] base);
    logic [23:0] m;
    m = 24'h000000;
    if (idx == base) begin
      m = 24'h0000FF;
    end else if (idx == base + 16'h0001) begin
      m = 24'h00FF00;
    end else if (idx == base + 16'h0002) begin
      m = 24'hFF0000;
    end
    return m;
  endfunction

  // ****************************************************************
  // AHB-Lite slave, one wait state per transfer
  // ****************************************************************
  assign addr_phase = hsel && hready && (htrans == HTRANS_NSEQ);
  assign wr_en      = bus_pend_q && bus_wr_q && bus_ok_q;
  assign wr_byte    = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_pend_q <= 1'b0;
      bus_wr_q   <= 1'b0;
      bus_idx_q  <= 16'h0000;
      bus_ok_q   <= 1'b0;
      hreadyout  <= 1'b1;
    end else begin
      bus_pend_q <= addr_phase;
      hreadyout  <= !addr_phase;
      if (addr_phase) begin
        bus_wr_q  <= hwrite;
        bus_idx_q <= haddr[17:2];
        bus_ok_q  <= (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (bus_idx_q)
      IDX_IF0: rd_byte = if_q[7:0];
      IDX_IF1: rd_byte = if_q[15:8];
      IDX_IF2: rd_byte = if_q[23:16] & SRC_MASK[23:16];
      IDX_MK0: rd_byte = mk_q[7:0];
      IDX_MK1: rd_byte = mk_q[15:8];
      IDX_MK2: rd_byte = mk_q[23:16] | ~SRC_MASK[23:16];
      IDX_PR0: rd_byte = pr_q[7:0];
      IDX_PR1: rd_byte = pr_q[15:8];
      IDX_PR2: rd_byte = pr_q[23:16] | ~SRC_MASK[23:16];
      IDX_KWS: rd_byte = kws_q;
      IDX_PSW: rd_byte = (psw_q & PSW_RW_MASK) | PSW_FIXED;
      IDX_SVC: rd_byte = {3'h0, last_vec_q};
      default: rd_byte = 8'h00;
    endcase
    if (!bus_ok_q) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hresp  <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
      if (bus_pend_q && !bus_wr_q) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ****************************************************************
  // Key wake detection on port 0
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kws_q <= KWS_RESET;
    end else if (wr_en && bus_idx_q == IDX_KWS) begin
      // Bits 1 to 3 are kept zero even if software slips
      kws_q <= wr_byte & KWS_RW_MASK;
    end
  end

  // Pin levels are read whatever the port direction, so turning a
  // selected pin into an output leaves detection running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_s1_q <= 8'hFF;
      p0_s2_q <= 8'hFF;
    end else begin
      p0_s1_q <= p0_pin;
      p0_s2_q <= p0_s1_q;
    end
  end

  assign key_sel   = {kws_q[7:4], {4{kws_q[KWS_GROUP]}}};
  // One AND over selected pins: while any is low no new fall can show
  assign keys_high = &(p0_s2_q | ~key_sel);
  assign key_event = keys_high_q && !keys_high && (|key_sel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      keys_high_q <= 1'b1;
    end else begin
      keys_high_q <= keys_high;
    end
  end

  // ****************************************************************
  // Request, mask and priority flags
  // ****************************************************************
  // Byte lanes of the request flags hit by the current bus write
  assign if_lanes = lane_mask(bus_idx_q, IDX_IF0);

  // Hardware set wins over both software clear and acknowledge clear
  always_comb begin
    if_d = if_q;
    if (wr_en) begin
      for (int k = 0; k < 3; k++) begin
        if (if_lanes[8*k]) begin
          if_d[8*k +: 8] = wr_byte;
        end
      end
    end
    if (take_mask) begin
      if_d[pick[4:0]] = 1'b0;
    end
    if_d[18:0]       = if_d[18:0] | src_req;
    if_d[KEY_IF_BIT] = if_d[KEY_IF_BIT] | key_event;
    if_d             = if_d & SRC_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      if_q <= IF_RESET;
    end else begin
      if_q <= if_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mk_q <= MK_RESET;
      pr_q <= PR_RESET;
    end else if (wr_en) begin
      mk_q <= (mk_q & ~lane_mask(bus_idx_q, IDX_MK0))
            | ({3{wr_byte}} & lane_mask(bus_idx_q, IDX_MK0));
      pr_q <= (pr_q & ~lane_mask(bus_idx_q, IDX_PR0))
            | ({3{wr_byte}} & lane_mask(bus_idx_q, IDX_PR0));
    end
  end

  // ****************************************************************
  // Acceptance at instruction boundaries
  // ****************************************************************
  // Mask 0 lets the source through; enable bit gates all of them
  assign eligible = if_q & ~mk_q & SRC_MASK
                  & {FLAG_BITS{psw_q[PSW_IE]}};
  // Only flags already standing one clock before the boundary count;
  // a flag raised in the last clock waits for the next boundary
  assign ripe     = eligible & pend_q;
  assign pick     = pick_src(ripe, pr_q);
  // Flag register instructions block every type of request
  assign take_nmi  = instr_last && !instr_flag_access && nmi_q;
  assign take_mask = instr_last && !instr_flag_access && !nmi_q
                   && pick[5];

  // Pending state is the eligible flags one clock late, reloaded every clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 24'h000000;
    end else begin
      pend_q <= eligible;
    end
  end

  // No in-service lock, so a fresh NMI request preempts a running routine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= (nmi_q && !take_nmi) || nmi_req;
    end
  end

  // ****************************************************************
  // Status byte
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psw_q <= PSW_RESET;
    end else begin
      if (return_from_service_strobe) begin
        psw_q <= (return_from_service_psw & PSW_RW_MASK) | PSW_FIXED;
      end else if (wr_en && bus_idx_q == IDX_PSW) begin
        psw_q <= (wr_byte & PSW_RW_MASK) | PSW_FIXED;
      end else begin
        if (alu_flags_we) begin
          psw_q[PSW_Z]  <= alu_z;
          psw_q[PSW_AC] <= alu_ac;
          psw_q[PSW_CY] <= alu_cy;
        end
        if (ei_strobe) begin
          psw_q[PSW_IE] <= 1'b1;
        end else if (di_strobe) begin
          psw_q[PSW_IE] <= 1'b0;
        end
      end
      // Acceptance clears the enable last so it overrides any update
      if (take_nmi || take_mask) begin
        psw_q[PSW_IE] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Service entry outputs
  // ****************************************************************
  // Core pushes svc_saved_psw first, then the PC, then jumps to the
  // vector; with its fixed entry cycles this gives 9 to 19 clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_start     <= 1'b0;
      svc_nmi       <= 1'b0;
      svc_vector    <= 5'h00;
      svc_saved_psw <= PSW_RESET;
      last_vec_q    <= 5'h00;
    end else begin
      svc_start <= take_nmi || take_mask;
      svc_nmi   <= take_nmi;
      if (take_nmi) begin
        svc_vector    <= NMI_VECTOR;
        svc_saved_psw <= (psw_q & PSW_RW_MASK) | PSW_FIXED;
        last_vec_q    <= NMI_VECTOR;
      end else if (take_mask) begin
        svc_vector    <= pick[4:0];
        svc_saved_psw <= (psw_q & PSW_RW_MASK) | PSW_FIXED;
        last_vec_q    <= pick[4:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psw_out <= PSW_RESET;
    end else begin
      psw_out <= (psw_q & PSW_RW_MASK) | PSW_FIXED;
    end
  end

endmodule

`default_nettype wire

/* File: iakw_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Core sequencer stand-in
// ****************
module iakw_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Instruction shape
  input  wire logic [3:0] len,
  input  wire logic       flag_op,
  // Towards the block
  output var  logic       instr_last,
  output var  logic       instr_flag_access
);
  logic [3:0] cnt_q;
  // Lengths 4 to 10; the compare is >= so a shorter length never wraps
  assign instr_last = (cnt_q >= len - 4'h1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_q <= 4'h0;
    else if (instr_last) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  // Turns only at a boundary, so it covers whole instructions
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) instr_flag_access <= 1'h0;
    else if (instr_last) instr_flag_access <= flag_op;
  end
endmodule
`default_nettype wire

/* File: iakw_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module iakw_top_assertions
  import iakw_pkg::*;
(
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Register bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic [1:0] hresp,
  // Core side
  input wire logic       instr_last,
  input wire logic       instr_flag_access,
  input wire logic       return_from_service_strobe,
  input wire logic [7:0] return_from_service_psw,
  input wire logic       svc_start,
  input wire logic       svc_nmi,
  input wire logic [4:0] svc_vector,
  input wire logic [7:0] svc_saved_psw,
  input wire logic [7:0] psw_out
);
  // ****************
  // Sequences
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_addr;
    hsel && hready && htrans == HTRANS_NSEQ;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_held;
    instr_last && instr_flag_access;
  endsequence
  // ****************
  // Checks
  // ****************
  bus_wait_a: assert property (s_addr |=> s_wait)
    else $error("bus wait state not one cycle");
  resp_okay_a: assert property (hresp == HRESP_OKAY)
    else $error("bus response not okay");
  fixed_bits_a: assert property ((psw_out & 8'h2E) == PSW_FIXED)
    else $error("status fixed bits wrong");
  start_cause_a: assert property (svc_start |->
    $past(instr_last) && !$past(instr_flag_access))
    else $error("service start without free boundary");
  hold_off_a: assert property (s_held |=> !svc_start)
    else $error("service start after held boundary");
  saved_psw_a: assert property (svc_start |->
    svc_saved_psw == psw_out)
    else $error("saved status differs");
  ie_clear_a: assert property (svc_start |=> !psw_out[PSW_IE])
    else $error("enable bit not cleared on accept");
  mask_gate_a: assert property (svc_start && !svc_nmi |->
    svc_saved_psw[PSW_IE] && svc_vector < 5'h14)
    else $error("maskable accept while disabled");
  nmi_vector_a: assert property (svc_start && svc_nmi |->
    svc_vector == NMI_VECTOR)
    else $error("non-maskable vector wrong");
  return_from_service_restore_a: assert property (return_from_service_strobe && !instr_last |=>
    ##1 psw_out == $past(return_from_service_psw, 2))
    else $error("return did not restore status");
endmodule
`default_nettype wire

/* File: iakw_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module iakw_top_bench;
  import iakw_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        nmi_req = 1'h0, ei_strobe = 1'h0, di_strobe = 1'h0;
  logic        alu_flags_we = 1'h0, alu_z = 1'h0, alu_ac = 1'h0;
  logic        alu_cy = 1'h0, return_from_service_strobe = 1'h0, flag_op = 1'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = 2'h0, hresp;
  logic [2:0]  hsize = 3'h2;
  logic [18:0] src_req = '0;
  logic [7:0]  p0_pin = 8'hFF, return_from_service_psw = 8'h02, svc_saved_psw, psw_out;
  logic [3:0]  ilen = 4'h4;
  logic [4:0]  svc_vector;
  logic        hreadyout, instr_last, instr_flag_access, svc_start, svc_nmi;
  int          n_fail = 0, checked = 0;

  iakw_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src_req(src_req), .nmi_req(nmi_req),
    .p0_pin(p0_pin), .instr_last(instr_last),
    .instr_flag_access(instr_flag_access), .ei_strobe(ei_strobe),
    .di_strobe(di_strobe), .alu_flags_we(alu_flags_we), .alu_z(alu_z),
    .alu_ac(alu_ac), .alu_cy(alu_cy), .return_from_service_strobe(return_from_service_strobe),
    .return_from_service_psw(return_from_service_psw), .svc_start(svc_start), .svc_nmi(svc_nmi),
    .svc_vector(svc_vector), .svc_saved_psw(svc_saved_psw),
    .psw_out(psw_out));
  iakw_core_model i_core (.clk(hclk), .rstn(hresetn), .len(ilen),
    .flag_op(flag_op), .instr_last(instr_last),
    .instr_flag_access(instr_flag_access));

  initial forever #5 hclk = ~hclk;
  // ****************
  // Helpers
  // ****************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Single word transfer; the second pass is the data phase
  task bus(input logic [15:0] i, input logic w, input logic [7:0] d,
           output logic [7:0] r);
    int n;
    hsel <= 1'h1;
    haddr <= {14'h0, i, 2'h0};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'h1 && n < 50);
      if (hreadyout !== 1'h1) begin
        n_fail++;
        wrap_up;
      end
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
    end
    r = hrdata[7:0];
  endtask
  task wr(input logic [15:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(i, 1'h1, d, r);
  endtask
  task rdc(input string nm, input logic [15:0] i, input logic [7:0] e);
    logic [7:0] r;
    bus(i, 1'h0, 8'h00, r);
    chk(nm, r, e);
  endtask
  // Quiet checks rely on the limit running out with no start seen
  task wait_svc(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (svc_start !== 1'h1 && n < lim);
  endtask
  task pulse_ctl(input logic ei, input logic di, input logic ret);
    ei_strobe <= ei;
    di_strobe <= di;
    return_from_service_strobe <= ret;
    @(posedge hclk);
    {ei_strobe, di_strobe, return_from_service_strobe} <= 3'h0;
  endtask
  task pulse_src(input logic [18:0] m, input logic nmi);
    src_req <= m;
    nmi_req <= nmi;
    @(posedge hclk);
    src_req <= '0;
    nmi_req <= 1'h0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_regs;
    rdc("status", IDX_PSW, 8'h02);
    rdc("key sel", IDX_KWS, 8'h00);
    rdc("mask0", IDX_MK0, 8'hFF);
    rdc("mask2", IDX_MK2, 8'hFF);
    wr(16'h0100, 8'h5A);
    rdc("unmapped", 16'h0100, 8'h00);
    wr(IDX_KWS, 8'hF1);
    rdc("key sel", IDX_KWS, 8'hF1);
    wr(IDX_KWS, 8'h00);
    {alu_flags_we, alu_z, alu_ac, alu_cy} <= 4'hF;
    @(posedge hclk);
    alu_flags_we <= 1'h0;
    rdc("alu flags", IDX_PSW, 8'h53);
    wr(IDX_PSW, 8'h02);
  endtask
  task t_nmi;
    // Second pass lands inside the first routine
    for (int k = 0; k < 2; k++) begin
      pulse_src('0, 1'h1);
      wait_svc(30);
      chk("nmi start", svc_start, 1'h1);
      chk("nmi flag", svc_nmi, 1'h1);
      chk("nmi vector", svc_vector, NMI_VECTOR);
    end
    pulse_ctl(1'h0, 1'h0, 1'h1);
  endtask
  task t_prio;
    ilen <= 4'hA;
    wr(IDX_MK0, 8'hDE);
    wr(IDX_PR0, 8'hDF);
    pulse_ctl(1'h1, 1'h0, 1'h0);
    pulse_src(19'h00021, 1'h0);
    wait_svc(18);
    chk("start", svc_start, 1'h1);
    chk("vector", svc_vector, 5'h05);
    chk("saved status", svc_saved_psw, 8'h82);
    rdc("flags0", IDX_IF0, 8'h01);
    wait_svc(30);
    chk("nested", svc_start, 1'h0);
    return_from_service_psw <= 8'h82;
    pulse_ctl(1'h0, 1'h0, 1'h1);
    wait_svc(30);
    chk("pending", svc_start, 1'h1);
    chk("vector", svc_vector, 5'h00);
    rdc("flags0", IDX_IF0, 8'h00);
    ilen <= 4'h4;
  endtask
  task t_gate;
    pulse_ctl(1'h1, 1'h0, 1'h0);
    pulse_src(19'h00002, 1'h0);
    wait_svc(30);
    chk("masked", svc_start, 1'h0);
    pulse_ctl(1'h0, 1'h1, 1'h0);
    wr(IDX_MK0, 8'hDC);
    wait_svc(30);
    chk("disabled", svc_start, 1'h0);
    pulse_ctl(1'h1, 1'h0, 1'h0);
    wait_svc(30);
    chk("enabled", svc_start, 1'h1);
    chk("vector", svc_vector, 5'h01);
  endtask
  task t_hold;
    flag_op <= 1'h1;
    for (int k = 0; k < 12 && instr_flag_access !== 1'h1; k++)
      @(posedge hclk);
    pulse_src('0, 1'h1);
    wait_svc(30);
    chk("held", svc_start, 1'h0);
    flag_op <= 1'h0;
    wait_svc(30);
    chk("released", svc_start, 1'h1);
  endtask
  task t_key;
    wr(IDX_MK2, 8'hFF);
    wr(IDX_KWS, 8'h10);
    wr(IDX_IF2, 8'h00);
    wr(IDX_MK2, 8'hF7);
    pulse_ctl(1'h1, 1'h0, 1'h0);
    p0_pin <= 8'hEF;
    wait_svc(20);
    chk("key start", svc_start, 1'h1);
    chk("key vector", svc_vector, KEY_IF_BIT);
    p0_pin <= 8'hFF;
    wr(IDX_MK2, 8'hFF);
    wr(IDX_KWS, 8'h11);
    wr(IDX_IF2, 8'h00);
    p0_pin <= 8'hFE;
    wr(IDX_PR2, 8'hFF);
    rdc("key group", IDX_IF2, 8'h08);
    wr(IDX_IF2, 8'h00);
    p0_pin <= 8'hEE;
    wr(IDX_PR2, 8'hFF);
    rdc("key held low", IDX_IF2, 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs;
    t_nmi;
    t_prio;
    t_gate;
    t_hold;
    t_key;
    wrap_up;
  end
endmodule

bind iakw_top iakw_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .instr_last(instr_last),
  .instr_flag_access(instr_flag_access), .return_from_service_strobe(return_from_service_strobe),
  .return_from_service_psw(return_from_service_psw), .svc_start(svc_start), .svc_nmi(svc_nmi),
  .svc_vector(svc_vector), .svc_saved_psw(svc_saved_psw),
  .psw_out(psw_out));
`default_nettype wire
